//--- verilog/aec_cfg.svh
/*
 Offsets, field positions, reset values and counts for the adaptive
 equalizer control block. Assumes inclusion by bare name, once per unit.
*/
`ifndef AEC_CFG_SVH
`define AEC_CFG_SVH
`define AEC_ADDR_W 8
`define AEC_DATA_W 8
`define AEC_ADDR_CTL 8'h42
`define AEC_ADDR_THR 8'h43
`define AEC_CTL_RST 8'h01
`define AEC_THR_RST 8'h01
`define AEC_CTL_WMASK 8'h7f
`define AEC_ERR_HI 6
`define AEC_ERR_LO 4
`define AEC_TWO_STEP_BIT 2
`define AEC_LOOP_ORDER_BIT 1
`define AEC_SF_EN_BIT 0
`define AEC_PERIOD_W 16
`define AEC_SET_W 4
`define AEC_SET_MAX 4'hf
`endif

//--- verilog/aec_pkg.sv
/*
 Types for the adaptive equalizer control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package aec_pkg;
   typedef enum logic [1:0] {
      AEC_IDLE,
      AEC_SETTLE,
      AEC_CHECK,
      AEC_MONITOR
   } aec_state_t;
endpackage

//--- verilog/aec_timer.sv
/*
 Down counter that fires one pulse when a loaded wait has elapsed.
 Assumes load is a one-cycle pulse; a load restarts any running wait.
*/
`timescale 1ns/1ns
`default_nettype none
`include "aec_cfg.svh"
module aec_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic load,
   input wire logic [`AEC_PERIOD_W-1:0] load_val,
   // Status
   output logic done
);
   logic [`AEC_PERIOD_W-1:0] cnt_ff;
   logic [`AEC_PERIOD_W-1:0] nxt_cnt;
   wire logic running;

   // Zero load is treated as one cycle so the machine never stalls
   assign running = (cnt_ff != {`AEC_PERIOD_W{1'b0}});
   // Not gated by load, since the caller builds load from done
   assign done = (cnt_ff == {{(`AEC_PERIOD_W-1){1'b0}}, 1'b1});
   assign nxt_cnt = load ? ((load_val == {`AEC_PERIOD_W{1'b0}}) ?
                            {{(`AEC_PERIOD_W-1){1'b0}}, 1'b1} : load_val) :
                    running ? cnt_ff - {{(`AEC_PERIOD_W-1){1'b0}}, 1'b1} : cnt_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= {`AEC_PERIOD_W{1'b0}};
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule
`default_nettype wire

//--- verilog/aec_err_acc.sv
/*
 Saturating error accumulator compared against the threshold.
 Assumes clr and inc are synchronous levels; clr wins over inc.
*/
`timescale 1ns/1ns
`default_nettype none
`include "aec_cfg.svh"
module aec_err_acc (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic clr,
   input wire logic inc,
   input wire logic [`AEC_DATA_W-1:0] threshold,
   // Status
   output logic over
);
   logic [`AEC_DATA_W-1:0] cnt_ff;
   logic [`AEC_DATA_W-1:0] nxt_cnt;
   wire logic sat;
   wire logic [`AEC_DATA_W-1:0] cnt_inc;

   // Saturation keeps a long error burst from wrapping below threshold
   assign sat = (cnt_ff == {`AEC_DATA_W{1'b1}});
   assign cnt_inc = (inc && !sat) ? cnt_ff + {{(`AEC_DATA_W-1){1'b0}}, 1'b1} : cnt_ff;
   assign nxt_cnt = clr ? {`AEC_DATA_W{1'b0}} : cnt_inc;
   // The closing cycle counts too, so the window spans a full half period
   assign over = (cnt_inc > threshold);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= {`AEC_DATA_W{1'b0}};
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule
`default_nettype wire

//--- verilog/aec_ctrl.sv
/*
 Adaptive equalizer control: register pair, validation state machine,
 error monitor and equalizer / secondary filter stepping.
 Assumes a register port decoded from the serial control bus, error and
 lock indications synchronous to clk, and a relock period in clk cycles.
*/
`timescale 1ns/1ns
`default_nettype none
`include "aec_cfg.svh"
module aec_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,

   // Register port
   input wire logic [`AEC_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [`AEC_DATA_W-1:0] reg_wdata,
   output logic [`AEC_DATA_W-1:0] reg_rdata,

   // Timing configuration
   input wire logic [`AEC_PERIOD_W-1:0] relock_period,

   // Link receiver status
   input wire logic adapt_start,
   input wire logic lock_det,
   input wire logic err_clk_bit,
   input wire logic err_seq,
   input wire logic err_parity,

   // Equalizer outputs
   output logic [`AEC_SET_W-1:0] eq_setting,
   output logic [`AEC_SET_W-1:0] secondary_filter_setting,
   output logic adapt_locked,
   output logic adapt_busy
);
   // Registers
   logic [`AEC_DATA_W-1:0] ctl_ff;
   logic [`AEC_DATA_W-1:0] thr_ff;
   logic [`AEC_DATA_W-1:0] rdata_ff;
   logic [`AEC_DATA_W-1:0] nxt_rdata;
   aec_pkg::aec_state_t state_ff;
   aec_pkg::aec_state_t nxt_state;
   logic [`AEC_SET_W-1:0] eq_ff;
   logic [`AEC_SET_W-1:0] sf_ff;
   logic [`AEC_SET_W-1:0] nxt_eq;
   logic [`AEC_SET_W-1:0] nxt_sf;

   // Decode
   wire logic ctl_sel;
   wire logic thr_sel;
   wire logic [2:0] error_source_enables;
   wire logic two_step_validate_enable;
   wire logic loop_order_select;
   wire logic secondary_filter_adapt_enable;

   // Register strobes and views
   wire logic ctl_we;
   wire logic thr_we;
   wire logic [`AEC_DATA_W-1:0] ctl_wr_val;
   wire logic [`AEC_DATA_W-1:0] ctl_view;

   assign ctl_sel = (reg_addr == `AEC_ADDR_CTL);
   assign thr_sel = (reg_addr == `AEC_ADDR_THR);
   assign error_source_enables = ctl_ff[`AEC_ERR_HI:`AEC_ERR_LO];
   assign two_step_validate_enable = ctl_ff[`AEC_TWO_STEP_BIT];
   assign loop_order_select = ctl_ff[`AEC_LOOP_ORDER_BIT];
   assign secondary_filter_adapt_enable = ctl_ff[`AEC_SF_EN_BIT];
   assign ctl_we = reg_wr_en && ctl_sel;
   assign thr_we = reg_wr_en && thr_sel;
   // Reserved bit 7 is never stored, so it always reads zero
   assign ctl_wr_val = reg_wdata & `AEC_CTL_WMASK;
   assign ctl_view = ctl_ff & `AEC_CTL_WMASK;

   // Unmapped addresses read zero
   assign nxt_rdata = !reg_rd_en ? rdata_ff :
                      ctl_sel ? ctl_view :
                      thr_sel ? thr_ff : {`AEC_DATA_W{1'b0}};

   // Error sources
   wire logic [2:0] err_vec;
   wire logic any_err;

   // All enables clear means no error is ever counted
   assign err_vec = {err_clk_bit, err_seq, err_parity} & error_source_enables;
   assign any_err = |err_vec;

   // Periods
   wire logic [`AEC_PERIOD_W-1:0] full_period;
   wire logic [`AEC_PERIOD_W-1:0] half_period;

   assign full_period = relock_period;
   // Odd periods round the half down
   assign half_period = {1'b0, relock_period[`AEC_PERIOD_W-1:1]};

   // Setting step
   wire logic eq_at_max;
   wire logic sf_at_max;
   wire logic [`AEC_SET_W-1:0] eq_inc;
   wire logic [`AEC_SET_W-1:0] sf_inc;
   wire logic [`AEC_SET_W-1:0] step_eq;
   wire logic [`AEC_SET_W-1:0] step_sf;

   assign eq_at_max = (eq_ff == `AEC_SET_MAX);
   assign sf_at_max = (sf_ff == `AEC_SET_MAX);
   assign eq_inc = eq_ff + {{(`AEC_SET_W-1){1'b0}}, 1'b1};
   assign sf_inc = sf_ff + {{(`AEC_SET_W-1){1'b0}}, 1'b1};

   // Inner loop steps each time; outer loop steps when inner wraps
   wire logic eq_carry;
   wire logic sf_carry;

   assign eq_carry = eq_at_max && !loop_order_select;
   assign sf_carry = sf_at_max && loop_order_select;
   assign step_eq = !secondary_filter_adapt_enable ? eq_inc :
                    (!loop_order_select || sf_carry) ? eq_inc : eq_ff;
   assign step_sf = !secondary_filter_adapt_enable ? sf_ff :
                    (loop_order_select || eq_carry) ? sf_inc : sf_ff;

   // State decode
   wire logic in_idle;
   wire logic in_settle;
   wire logic in_check;
   wire logic in_monitor;

   // Idle only until the first start; there is no way back
   assign in_idle = (state_ff == aec_pkg::AEC_IDLE);
   assign in_settle = (state_ff == aec_pkg::AEC_SETTLE);
   assign in_check = (state_ff == aec_pkg::AEC_CHECK);
   assign in_monitor = (state_ff == aec_pkg::AEC_MONITOR);

   // Helper instances
   logic tmr_load;
   logic [`AEC_PERIOD_W-1:0] tmr_val;
   logic acc_clr;
   wire logic tmr_done;
   wire logic acc_over;
   wire logic acc_inc;

   // Only a settled setting is scored against the threshold
   assign acc_inc = any_err && in_monitor;

   aec_timer u_timer (
      .clk(clk),
      .rst_b(rst_b),
      .load(tmr_load),
      .load_val(tmr_val),
      .done(tmr_done)
   );

   aec_err_acc u_err_acc (
      .clk(clk),
      .rst_b(rst_b),
      .clr(acc_clr),
      .inc(acc_inc),
      .threshold(thr_ff),
      .over(acc_over)
   );

   // Ways out of each state
   wire logic start_take;
   wire logic settle_fail;
   wire logic check_fail;
   wire logic window_fail;
   wire logic wait_end;

   // Start is ignored mid-search so a half-judged setting is never lost
   assign start_take = adapt_start && (in_idle || in_monitor);
   assign settle_fail = tmr_done && !lock_det;
   assign check_fail = any_err || settle_fail;
   // Lock loss steps at once instead of waiting out the window
   assign window_fail = !lock_det || (tmr_done && acc_over);
   assign wait_end = tmr_done;

   // First wait length depends on the validation mode
   wire logic [`AEC_PERIOD_W-1:0] settle_period;

   assign settle_period = two_step_validate_enable ? half_period : full_period;

   // Next-state logic
   always_comb begin
      nxt_state = state_ff;
      nxt_eq = eq_ff;
      nxt_sf = sf_ff;
      tmr_load = 1'b0;
      tmr_val = settle_period;
      acc_clr = 1'b0;
      unique case (state_ff)
         aec_pkg::AEC_IDLE: begin
            if (start_take) begin
               nxt_eq = {`AEC_SET_W{1'b0}};
               nxt_sf = {`AEC_SET_W{1'b0}};
               tmr_load = 1'b1;
               nxt_state = aec_pkg::AEC_SETTLE;
            end
         end
         aec_pkg::AEC_SETTLE: begin
            if (wait_end) begin
               tmr_load = 1'b1;
               acc_clr = 1'b1;
               if (!lock_det) begin
                  // Setting failed; try the next one
                  nxt_eq = step_eq;
                  nxt_sf = step_sf;
               end else if (two_step_validate_enable) begin
                  tmr_val = half_period;
                  nxt_state = aec_pkg::AEC_CHECK;
               end else begin
                  tmr_val = half_period;
                  nxt_state = aec_pkg::AEC_MONITOR;
               end
            end
         end
         aec_pkg::AEC_CHECK: begin
            if (check_fail) begin
               // An error abandons the setting at once
               nxt_eq = step_eq;
               nxt_sf = step_sf;
               tmr_load = 1'b1;
               nxt_state = aec_pkg::AEC_SETTLE;
            end else if (wait_end) begin
               tmr_load = 1'b1;
               tmr_val = half_period;
               acc_clr = 1'b1;
               nxt_state = aec_pkg::AEC_MONITOR;
            end
         end
         aec_pkg::AEC_MONITOR: begin
            if (start_take) begin
               nxt_eq = {`AEC_SET_W{1'b0}};
               nxt_sf = {`AEC_SET_W{1'b0}};
               tmr_load = 1'b1;
               nxt_state = aec_pkg::AEC_SETTLE;
            end else if (window_fail) begin
               // Too many errors in one half period: go stronger
               nxt_eq = step_eq;
               nxt_sf = step_sf;
               tmr_load = 1'b1;
               acc_clr = 1'b1;
               nxt_state = aec_pkg::AEC_SETTLE;
            end else if (wait_end) begin
               tmr_load = 1'b1;
               tmr_val = half_period;
               acc_clr = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_ff <= `AEC_CTL_RST;
      end else if (ctl_we) begin
         ctl_ff <= ctl_wr_val;
      end
   end

   // Threshold zero is not guarded; any error then triggers stepping
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         thr_ff <= `AEC_THR_RST;
      end else if (thr_we) begin
         thr_ff <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= {`AEC_DATA_W{1'b0}};
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= aec_pkg::AEC_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Settings move only on a step or a start, so the receiver sees no glitch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         eq_ff <= {`AEC_SET_W{1'b0}};
         sf_ff <= {`AEC_SET_W{1'b0}};
      end else begin
         eq_ff <= nxt_eq;
         sf_ff <= nxt_sf;
      end
   end

   // Outputs
   assign reg_rdata = rdata_ff;
   assign eq_setting = eq_ff;
   assign secondary_filter_setting = sf_ff;
   // Status is a plain state decode, no extra flop delay
   assign adapt_locked = in_monitor;
   assign adapt_busy = in_settle || in_check;
endmodule
`default_nettype wire

//--- sim/aec_ctrl_asserts.sv
/* Port checker for aec_ctrl, bound at the foot.
   Assumes register shadows can follow the writes seen on the ports. */
`timescale 1ns/1ns
`default_nettype none
module aec_ctrl_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Registers
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Adaptation
   input wire logic adapt_start,
   input wire logic lock_det,
   input wire logic [3:0] eq_setting,
   input wire logic [3:0] secondary_filter_setting,
   input wire logic adapt_locked,
   input wire logic adapt_busy
);
   logic [7:0] ctl_ff;
   logic [7:0] thr_ff;
   wire [3:0] sf = secondary_filter_setting;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_ff <= 8'h01;
         thr_ff <= 8'h01;
      end else if (reg_wr_en && reg_addr == 8'h42) begin
         ctl_ff <= reg_wdata & 8'h7f;
      end else if (reg_wr_en && reg_addr == 8'h43) begin
         thr_ff <= reg_wdata;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Answer lands a cycle late, so judge two edges on
   sequence rd_of(a);
      reg_rd_en && reg_addr == a ##1 !reg_rd_en;
   endsequence
   ctl_read_a: assert property (rd_of(8'h42) |=> reg_rdata == $past(ctl_ff, 2))
      else $error("control read wrong");
   thr_read_a: assert property (rd_of(8'h43) |=> reg_rdata == $past(thr_ff, 2))
      else $error("threshold read wrong");
   start_clear_a: assert property (adapt_start && !adapt_busy
      |=> adapt_busy && eq_setting == 4'h0 && sf == 4'h0) else $error("start not taken");
   lock_loss_a: assert property (adapt_locked && !lock_det && !adapt_start |=> adapt_busy)
      else $error("lock loss ignored");
   eq_step_a: assert property ($changed(eq_setting) && eq_setting != 4'h0
      |-> eq_setting == 4'($past(eq_setting) + 4'h1)) else $error("eq step wrong");
   // Past control value, since a write may land on a stepping edge
   filter_off_a: assert property (!$past(ctl_ff[0]) && $changed(sf) |-> sf == 4'h0)
      else $error("filter moved while off");
   filter_outer_a: assert property ($past(ctl_ff[1:0]) == 2'b01 && $changed(sf)
      && sf != 4'h0 |-> $past(eq_setting) == 4'hf) else $error("filter stepped early");
   eq_outer_a: assert property ($past(ctl_ff[1:0]) == 2'b11 && $changed(eq_setting)
      && eq_setting != 4'h0 |-> $past(sf) == 4'hf) else $error("eq stepped early");
endmodule
bind aec_ctrl aec_ctrl_asserts chk_i (.clk, .rst_b, .reg_addr, .reg_wr_en, .reg_rd_en,
   .reg_wdata, .reg_rdata, .adapt_start, .lock_det, .eq_setting, .secondary_filter_setting,
   .adapt_locked, .adapt_busy);
`default_nettype wire

//--- sim/aec_ser_model.sv
/* Far-end serializer stand-in: lock and error indications.
   Assumes the bench commands lock and bursting error sources. */
`timescale 1ns/1ns
`default_nettype none
module aec_ser_model (
   // Commands
   input wire logic lock_on,
   input wire logic [2:0] err_sel,
   // Link status
   output logic lock_det,
   output logic err_clk_bit,
   output logic err_seq,
   output logic err_parity
);
   // Bursts on every cycle, so a window always beats a small threshold
   assign lock_det = lock_on;
   assign {err_clk_bit, err_seq, err_parity} = err_sel;
endmodule
`default_nettype wire

//--- sim/test_adaptive_eq_control.sv
/* Self-checking bench for aec_ctrl with the far-end stand-in.
   Assumes a 100 ns clock and relock periods in clock cycles. */
`timescale 1ns/1ns
`default_nettype none
module test_adaptive_eq_control;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [15:0] relock_period = 16'h0008;
   logic adapt_start = 1'b0;
   logic lock_on = 1'b1;
   logic [2:0] err_sel = 3'h0;
   wire lock_det, err_clk_bit, err_seq, err_parity, adapt_locked, adapt_busy;
   wire [7:0] reg_rdata;
   wire [3:0] eq, sf;
   int bad_count = 0;
   int n_compared = 0;
   int n;
   logic [7:0] s, m;
   logic [7:0] modes [3] = '{8'h03, 8'h00, 8'h01};
   always #50 clk = ~clk;
   aec_ser_model far (.lock_on, .err_sel, .lock_det, .err_clk_bit, .err_seq, .err_parity);
   aec_ctrl dut (.clk, .rst_b, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
      .relock_period, .adapt_start, .lock_det, .err_clk_bit, .err_seq, .err_parity,
      .eq_setting(eq), .secondary_filter_setting(sf), .adapt_locked, .adapt_busy);
   task automatic results();
      if (bad_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One strobe, then a spare cycle so read data has landed
   task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = w;
      reg_rd_en = !w;
      @(negedge clk);
      reg_wr_en = 0;
      reg_rd_en = 0;
      @(negedge clk);
   endtask
   task automatic wait_idle();
      n = 0;
      while (adapt_busy !== 1'b0 && n < 999) begin
         n++;
         @(negedge clk);
      end
   endtask
   // Start is refused mid-search, so let the search end first
   task automatic kick();
      wait_idle();
      adapt_start = 1;
      @(negedge clk);
      adapt_start = 0;
   endtask
   function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] c);
      logic [3:0] e, f;
      e = v[7:4];
      f = v[3:0];
      if (c[0] && !c[1] && e == 4'hf) f = f + 4'h1;
      if (c[0] && c[1] && f == 4'hf) e = e + 4'h1;
      if (c[0] && c[1]) f = f + 4'h1;
      else e = e + 4'h1;
      return {e, f};
   endfunction
   initial begin
      #2000000;
      bad_count++;
      results();
   end
   initial begin
      void'($urandom(99));
      repeat (2) @(negedge clk);
      rst_b = 1;
      acc(8'h42, 8'h00, 0);
      chk(reg_rdata, 8'h01);
      acc(8'h43, 8'h00, 0);
      chk(reg_rdata, 8'h01);
      acc(8'h42, 8'hff, 1);
      acc(8'h42, 8'h00, 0);
      chk(reg_rdata, 8'h7f);
      m = 8'($urandom_range(255, 1));
      acc(8'h43, m, 1);
      acc(8'h44, 8'h00, 0);
      chk(reg_rdata, 8'h00);
      acc(8'h43, 8'h00, 0);
      chk(reg_rdata, m);
      acc(8'h43, 8'h01, 1);
      // One-step under errors: only the lock decides
      acc(8'h42, 8'h71, 1);
      err_sel = 3'h7;
      repeat (3) begin
         relock_period = 16'($urandom_range(12, 4));
         kick();
         wait_idle();
         chk(8'(n), 8'(relock_period));
      end
      relock_period = 16'h0008;
      for (int b = 0; b < 3; b++) begin
         err_sel = 3'h0;
         acc(8'h42, 8'h01 | (8'h10 << b), 1);
         kick();
         wait_idle();
         err_sel = 3'h7 ^ (3'h1 << b);
         repeat (12) @(negedge clk);
         chk({4'h0, eq}, 8'h00);
         err_sel = 3'h1 << b;
         repeat (12) @(negedge clk);
         chk({7'h0, eq != 4'h0}, 8'h01);
      end
      // Four errors a window: at the threshold holds, above it steps
      err_sel = 3'h0;
      acc(8'h42, 8'h11, 1);
      acc(8'h43, 8'h04, 1);
      kick();
      wait_idle();
      err_sel = 3'h1;
      repeat (12) @(negedge clk);
      chk({4'h0, eq}, 8'h00);
      acc(8'h43, 8'h03, 1);
      repeat (12) @(negedge clk);
      chk({7'h0, eq != 4'h0}, 8'h01);
      acc(8'h43, 8'h01, 1);
      err_sel = 3'h0;
      acc(8'h42, 8'h15, 1);
      kick();
      wait_idle();
      chk(8'(n), 8'h08);
      lock_on = 0;
      @(negedge clk);
      chk({7'h0, adapt_busy}, 8'h01);
      lock_on = 1;
      kick();
      err_sel = 3'h1;
      // Half wait, then the first error steps at once, twice over
      repeat (12) @(negedge clk);
      chk({3'h0, adapt_locked, eq}, 8'h02);
      err_sel = 3'h0;
      relock_period = 16'h0002;
      for (int i = 0; i < 3; i++) begin
         lock_on = 1;
         acc(8'h42, modes[i], 1);
         kick();
         lock_on = 0;
         s = 8'h00;
         repeat (120) begin
            @(negedge clk);
            if ({eq, sf} !== s) begin
               chk({eq, sf}, step(s, modes[i]));
               s = {eq, sf};
            end
         end
      end
      results();
   end
endmodule
`default_nettype wire
